// ---- include/dmaic_consts.svh ----
// register offsets, field positions and reset values of the dma index/irq block
// assumes word-addressed 8-bit register port with 16-bit data
`ifndef DMAIC_CONSTS_SVH
`define DMAIC_CONSTS_SVH

`define DMAIC_NCHAN        6
`define DMAIC_AW           8
`define DMAIC_DW           16

// global registers
`define DMAIC_OFF_ELEM_ADJ0  8'h00
`define DMAIC_OFF_ELEM_ADJ1  8'h01
`define DMAIC_OFF_FRAME_ADJ0 8'h02
`define DMAIC_OFF_FRAME_ADJ1 8'h03
`define DMAIC_OFF_PRIO_EN    8'h04
`define DMAIC_OFF_IRQ_STAT   8'h05
`define DMAIC_OFF_IRQ_MASK   8'h06

// per-channel block: base + channel * stride + field offset
`define DMAIC_CHAN_BASE      8'h10
`define DMAIC_CHAN_STRIDE    8'h08
`define DMAIC_CH_MODE        3'h0
`define DMAIC_CH_SYNC        3'h1
`define DMAIC_CH_COUNT       3'h2
`define DMAIC_CH_RELOAD      3'h3
`define DMAIC_CH_SRC         3'h4
`define DMAIC_CH_DST         3'h5

// mode control fields
`define DMAIC_MODE_DST_SEL   0
`define DMAIC_MODE_SRC_SEL   1
`define DMAIC_MODE_SRC_ADJ   2
`define DMAIC_MODE_DST_ADJ   3
`define DMAIC_MODE_AUTOBUF   13
`define DMAIC_MODE_IRQ_MODE  14
`define DMAIC_MODE_IEN       15

// sync/frame-count fields
`define DMAIC_SYNC_HI        15
`define DMAIC_SYNC_LO        12
`define DMAIC_FRAME_HI       7
`define DMAIC_FRAME_LO       0

// priority/enable fields
`define DMAIC_PREC_EN_HI     5
`define DMAIC_PREC_ROUTE_HI  11
`define DMAIC_PREC_ROUTE_LO  10

// sync codes
`define DMAIC_SYNC_NONE      4'h0
`define DMAIC_SYNC_PORT_LO   4'h1
`define DMAIC_SYNC_VA_LO     4'h7
`define DMAIC_SYNC_VA_HI     4'hC
`define DMAIC_SYNC_TIMER     4'hD
`define DMAIC_SYNC_EXT3      4'hE

`define DMAIC_ROUTE_RESET    2'h0

`endif

// ---- include/dmaic_pkg.sv ----
// types shared by the dma index/irq block
// assumes dmaic_consts.svh holds every number but the word width and route codes below
package dmaic_pkg;

  typedef logic [15:0] dmaic_word_t;

  // routing of the shared cpu interrupt lines
  typedef enum logic [1:0]
  {
    DMAIC_ROUTE_PORTS = 2'h0,
    DMAIC_ROUTE_MIXED = 2'h1,
    DMAIC_ROUTE_CHANS = 2'h2,
    DMAIC_ROUTE_RSVD  = 2'h3
  } dmaic_route_t;

endpackage

// ---- rtl/dmaic_ctrl.sv ----
// six-channel dma address indexing, pacing and interrupt routing
// assumes a transfer engine reports each element read on elem_done
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "dmaic_consts.svh"

module dmaic_ctrl
  import dmaic_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        ce,
  // register port
  input  wire logic [`DMAIC_AW-1:0]        reg_addr,
  input  wire logic [`DMAIC_DW-1:0]        reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [`DMAIC_DW-1:0]        reg_rdata,
  // sync events, index 0..2 = serial port 0..2
  input  wire logic [2:0]                  port_rx_evt,
  input  wire logic [2:0]                  port_tx_evt,
  input  wire logic [2:0]                  port_rx_evt_va,
  input  wire logic [2:0]                  port_tx_evt_va,
  input  wire logic                        timer_evt,
  input  wire logic                        ext3_evt,
  // transfer engine
  output logic      [`DMAIC_NCHAN-1:0]     chan_go,
  input  wire logic [`DMAIC_NCHAN-1:0]     elem_done,
  // serial port interrupts sharing cpu lines
  input  wire logic                        port2_rx_irq,
  input  wire logic                        port2_tx_irq,
  input  wire logic                        port1_rx_irq,
  input  wire logic                        port1_tx_irq,
  // cpu interrupt lines
  output logic                             cpu_irq_6,
  output logic                             cpu_irq_7,
  output logic                             cpu_irq_10,
  output logic                             cpu_irq_11,
  output logic                             chan4_irq,
  output logic                             chan5_irq,
  output logic                             dma_irq
);

  localparam int NC = `DMAIC_NCHAN;

  dmaic_word_t elem_adj_0;
  dmaic_word_t elem_adj_1;
  dmaic_word_t frame_adj_0;
  dmaic_word_t frame_adj_1;
  dmaic_word_t chan_mode_ctrl       [NC];
  dmaic_word_t sync_frame_count_reg [NC];
  dmaic_word_t elem_counter         [NC];
  dmaic_word_t elem_reload          [NC];
  dmaic_word_t chan_src_addr        [NC];
  dmaic_word_t chan_dst_addr        [NC];
  logic [NC-1:0]  chan_enable;
  dmaic_route_t   irq_route_sel;
  logic [NC-1:0]  irq_status;
  logic [NC-1:0]  irq_mask;
  logic [NC-1:0]  sync_pending;
  logic [NC-1:0]  sync_hit;
  logic [NC-1:0]  irq_event;
  logic [NC-1:0]  block_end;
  logic [NC-1:0]  chan_irq;

  // per-channel register hit
  function automatic logic chan_hit(input logic [7:0] addr, input int ch,
                                    input logic [2:0] fld);
    logic [7:0] base;
    base = `DMAIC_CHAN_BASE + 8'(ch) * `DMAIC_CHAN_STRIDE;
    return addr == (base + {5'h00, fld});
  endfunction

  // signed post-adjustment of an address from a selected index set
  function automatic dmaic_word_t adjust(input dmaic_word_t addr, input logic last,
                                         input logic sel);
    dmaic_word_t amount;
    if (last)
      amount = sel ? frame_adj_1 : frame_adj_0;
    else
      amount = sel ? elem_adj_1 : elem_adj_0;
    return dmaic_word_t'($signed(addr) + $signed(amount));
  endfunction

  wire logic wr = ce & reg_wr;

  // pacing event per channel
  always_comb
  begin
    for (int c = 0; c < NC; c++)
    begin
      logic [3:0] code;
      code = sync_frame_count_reg[c][`DMAIC_SYNC_HI:`DMAIC_SYNC_LO];
      case (code)
        4'h1:    sync_hit[c] = port_rx_evt[0];
        4'h2:    sync_hit[c] = port_tx_evt[0];
        4'h3:    sync_hit[c] = port_rx_evt[2];
        4'h4:    sync_hit[c] = port_tx_evt[2];
        4'h5:    sync_hit[c] = port_rx_evt[1];
        4'h6:    sync_hit[c] = port_tx_evt[1];
        4'h7:    sync_hit[c] = port_rx_evt_va[0];
        4'h8:    sync_hit[c] = port_tx_evt_va[0];
        4'h9:    sync_hit[c] = port_rx_evt_va[2];
        4'hA:    sync_hit[c] = port_tx_evt_va[2];
        4'hB:    sync_hit[c] = port_rx_evt_va[1];
        4'hC:    sync_hit[c] = port_tx_evt_va[1];
        `DMAIC_SYNC_TIMER: sync_hit[c] = timer_evt;
        `DMAIC_SYNC_EXT3:  sync_hit[c] = ext3_evt;
        default: sync_hit[c] = 1'b0; // reserved code never paces
      endcase
    end
  end

  // element/frame bookkeeping decisions
  always_comb
  begin
    for (int c = 0; c < NC; c++)
    begin
      logic last;
      logic autobuf;
      logic half;
      last    = elem_counter[c] == 16'h0000;
      autobuf = chan_mode_ctrl[c][`DMAIC_MODE_AUTOBUF];
      half    = elem_counter[c] == {1'b0, elem_reload[c][15:1]} + 16'h0001;
      block_end[c] = elem_done[c] & last & ~autobuf &
                     (sync_frame_count_reg[c][`DMAIC_FRAME_HI:`DMAIC_FRAME_LO] == 8'h00);
      irq_event[c] = 1'b0;
      if (elem_done[c] && chan_mode_ctrl[c][`DMAIC_MODE_IEN])
      begin
        if (autobuf)
          irq_event[c] = last | (half & chan_mode_ctrl[c][`DMAIC_MODE_IRQ_MODE]);
        else if (chan_mode_ctrl[c][`DMAIC_MODE_IRQ_MODE])
          irq_event[c] = last;
        else
          irq_event[c] = block_end[c];
      end
    end
  end

  // global index registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      elem_adj_0  <= 16'h0000;
      elem_adj_1  <= 16'h0000;
      frame_adj_0 <= 16'h0000;
      frame_adj_1 <= 16'h0000;
    end
    else if (wr)
    begin
      if (reg_addr == `DMAIC_OFF_ELEM_ADJ0)
        elem_adj_0 <= reg_wdata;
      if (reg_addr == `DMAIC_OFF_ELEM_ADJ1)
        elem_adj_1 <= reg_wdata;
      if (reg_addr == `DMAIC_OFF_FRAME_ADJ0)
        frame_adj_0 <= reg_wdata;
      if (reg_addr == `DMAIC_OFF_FRAME_ADJ1)
        frame_adj_1 <= reg_wdata;
    end
  end

  // channel enables and routing; a finished block drops its enable
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      chan_enable   <= '0;
      irq_route_sel <= dmaic_route_t'(`DMAIC_ROUTE_RESET);
    end
    else if (ce)
    begin
      if (wr && reg_addr == `DMAIC_OFF_PRIO_EN)
      begin
        chan_enable   <= reg_wdata[`DMAIC_PREC_EN_HI:0];
        irq_route_sel <= dmaic_route_t'(reg_wdata[`DMAIC_PREC_ROUTE_HI:`DMAIC_PREC_ROUTE_LO]);
      end
      else
        chan_enable <= chan_enable & ~block_end;
    end
  end

  // per-channel control and software-loaded counters
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int c = 0; c < NC; c++)
      begin
        chan_mode_ctrl[c] <= 16'h0000;
        elem_reload[c]    <= 16'h0000;
      end
    end
    else if (wr)
    begin
      for (int c = 0; c < NC; c++)
      begin
        if (chan_hit(reg_addr, c, `DMAIC_CH_MODE))
          chan_mode_ctrl[c] <= reg_wdata;
        if (chan_hit(reg_addr, c, `DMAIC_CH_RELOAD))
          elem_reload[c] <= reg_wdata;
      end
    end
  end

  // counters and addresses; a software write overrides the same-cycle update
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int c = 0; c < NC; c++)
      begin
        sync_frame_count_reg[c] <= 16'h0000;
        elem_counter[c]         <= 16'h0000;
        chan_src_addr[c]        <= 16'h0000;
        chan_dst_addr[c]        <= 16'h0000;
      end
    end
    else if (ce)
    begin
      for (int c = 0; c < NC; c++)
      begin
        logic last;
        last = elem_counter[c] == 16'h0000;
        if (elem_done[c])
        begin
          if (chan_mode_ctrl[c][`DMAIC_MODE_SRC_ADJ])
            chan_src_addr[c] <= adjust(chan_src_addr[c], last,
                                       chan_mode_ctrl[c][`DMAIC_MODE_SRC_SEL]);
          if (chan_mode_ctrl[c][`DMAIC_MODE_DST_ADJ])
            chan_dst_addr[c] <= adjust(chan_dst_addr[c], last,
                                       chan_mode_ctrl[c][`DMAIC_MODE_DST_SEL]);
          if (!last)
            elem_counter[c] <= elem_counter[c] - 16'h0001;
          else
          begin
            elem_counter[c] <= elem_reload[c];
            if (!block_end[c] && !chan_mode_ctrl[c][`DMAIC_MODE_AUTOBUF])
              sync_frame_count_reg[c][7:0] <= sync_frame_count_reg[c][7:0] - 8'h01;
          end
        end
        if (wr && chan_hit(reg_addr, c, `DMAIC_CH_SYNC))
          sync_frame_count_reg[c] <= reg_wdata;
        if (wr && chan_hit(reg_addr, c, `DMAIC_CH_COUNT))
          elem_counter[c] <= reg_wdata;
        if (wr && chan_hit(reg_addr, c, `DMAIC_CH_SRC))
          chan_src_addr[c] <= reg_wdata;
        if (wr && chan_hit(reg_addr, c, `DMAIC_CH_DST))
          chan_dst_addr[c] <= reg_wdata;
      end
    end
  end

  // latched sync events; a new event beats the consuming element
  always_ff @(posedge clk)
  begin
    if (reset)
      sync_pending <= '0;
    else if (ce)
      sync_pending <= (sync_pending & ~elem_done) | sync_hit;
  end

  always_comb
  begin
    for (int c = 0; c < NC; c++)
    begin
      logic unsync;
      unsync = sync_frame_count_reg[c][`DMAIC_SYNC_HI:`DMAIC_SYNC_LO] == `DMAIC_SYNC_NONE;
      chan_go[c] = chan_enable[c] & (unsync | sync_pending[c]);
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_status <= '0;
      irq_mask   <= '0;
    end
    else if (ce)
    begin
      if (wr && reg_addr == `DMAIC_OFF_IRQ_STAT)
        irq_status <= (irq_status & ~reg_wdata[NC-1:0]) | irq_event;
      else
        irq_status <= irq_status | irq_event;
      if (wr && reg_addr == `DMAIC_OFF_IRQ_MASK)
        irq_mask <= reg_wdata[NC-1:0];
    end
  end

  assign chan_irq = irq_status & irq_mask;

  // cpu line routing, registered
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cpu_irq_6  <= 1'b0;
      cpu_irq_7  <= 1'b0;
      cpu_irq_10 <= 1'b0;
      cpu_irq_11 <= 1'b0;
      chan4_irq  <= 1'b0;
      chan5_irq  <= 1'b0;
      dma_irq    <= 1'b0;
    end
    else if (ce)
    begin
      case (irq_route_sel)
        DMAIC_ROUTE_MIXED:
        begin
          cpu_irq_6  <= port2_rx_irq;
          cpu_irq_7  <= port2_tx_irq;
          cpu_irq_10 <= chan_irq[2];
          cpu_irq_11 <= chan_irq[3];
        end
        DMAIC_ROUTE_CHANS:
        begin
          cpu_irq_6  <= chan_irq[0];
          cpu_irq_7  <= chan_irq[1];
          cpu_irq_10 <= chan_irq[2];
          cpu_irq_11 <= chan_irq[3];
        end
        default:
        begin
          // reserved code behaves as reset routing
          cpu_irq_6  <= port2_rx_irq;
          cpu_irq_7  <= port2_tx_irq;
          cpu_irq_10 <= port1_rx_irq;
          cpu_irq_11 <= port1_tx_irq;
        end
      endcase
      chan4_irq <= chan_irq[4];
      chan5_irq <= chan_irq[5];
      dma_irq   <= |chan_irq;
    end
  end

  // read port, data valid the cycle after the strobe only
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 16'h0000;
    else if (ce)
    begin
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `DMAIC_OFF_ELEM_ADJ0:  reg_rdata <= elem_adj_0;
          `DMAIC_OFF_ELEM_ADJ1:  reg_rdata <= elem_adj_1;
          `DMAIC_OFF_FRAME_ADJ0: reg_rdata <= frame_adj_0;
          `DMAIC_OFF_FRAME_ADJ1: reg_rdata <= frame_adj_1;
          `DMAIC_OFF_PRIO_EN:    reg_rdata <= {4'h0, irq_route_sel, 4'h0, chan_enable};
          `DMAIC_OFF_IRQ_STAT:   reg_rdata <= {10'h000, irq_status};
          `DMAIC_OFF_IRQ_MASK:   reg_rdata <= {10'h000, irq_mask};
          default:
          begin
            for (int c = 0; c < NC; c++)
            begin
              if (chan_hit(reg_addr, c, `DMAIC_CH_MODE))
                reg_rdata <= chan_mode_ctrl[c];
              if (chan_hit(reg_addr, c, `DMAIC_CH_SYNC))
                reg_rdata <= sync_frame_count_reg[c];
              if (chan_hit(reg_addr, c, `DMAIC_CH_COUNT))
                reg_rdata <= elem_counter[c];
              if (chan_hit(reg_addr, c, `DMAIC_CH_RELOAD))
                reg_rdata <= elem_reload[c];
              if (chan_hit(reg_addr, c, `DMAIC_CH_SRC))
                reg_rdata <= chan_src_addr[c];
              if (chan_hit(reg_addr, c, `DMAIC_CH_DST))
                reg_rdata <= chan_dst_addr[c];
            end
          end
        endcase
      end
    end
  end

endmodule // dmaic_ctrl

// ---- test/dmaic_ctrl_props.sv ----
// port checker of dmaic_ctrl
// assumes the bind below; shadows follow software writes only
`timescale 1ns/1ps

module dmaic_ctrl_props
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // pacing and lines
  input wire logic [5:0]  chan_go,
  input wire logic        port2_rx_irq,
  input wire logic        port2_tx_irq,
  input wire logic        port1_rx_irq,
  input wire logic        port1_tx_irq,
  input wire logic        cpu_irq_6,
  input wire logic        cpu_irq_7,
  input wire logic        cpu_irq_10,
  input wire logic        cpu_irq_11,
  input wire logic        dma_irq
);
  logic [1:0] route;
  logic [5:0] en;
  logic [5:0] mask;
  logic       hi_ports;
  logic       lo_ports;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  assign hi_ports = ce && route != 2'h2;
  assign lo_ports = ce && (route == 2'h0 || route == 2'h3);

  // hardware may clear enables, so en is only an upper bound
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      route <= 2'h0;
      en    <= 6'h00;
      mask  <= 6'h00;
    end
    else if (ce && reg_wr && reg_addr == 8'h04)
    begin
      route <= reg_wdata[11:10];
      en    <= reg_wdata[5:0];
    end
    else if (ce && reg_wr && reg_addr == 8'h06)
      mask <= reg_wdata[5:0];
  end

  sequence s_rd(logic [7:0] a);
    ce && reg_rd && reg_addr == a;
  endsequence

  property p_rd_idle;
    ce && !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  property p_rd_void;
    s_rd(8'h40) |=> reg_rdata == 16'h0000;
  endproperty
  property p_rd_route;
    s_rd(8'h04) |=> reg_rdata[11:10] == $past(route);
  endproperty
  property p_line6;
    hi_ports |=> cpu_irq_6 == $past(port2_rx_irq);
  endproperty
  property p_line7;
    hi_ports |=> cpu_irq_7 == $past(port2_tx_irq);
  endproperty
  property p_line10;
    lo_ports |=> cpu_irq_10 == $past(port1_rx_irq);
  endproperty
  property p_line11;
    lo_ports |=> cpu_irq_11 == $past(port1_tx_irq);
  endproperty
  property p_go_en;
    (chan_go & ~en) == 6'h00;
  endproperty
  property p_mask_quiet;
    ce && mask == 6'h00 |=> !dma_irq;
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  a_rd_void: assert property (p_rd_void)
    else $error("unmapped read not zero");
  a_rd_route: assert property (p_rd_route)
    else $error("route field read back wrong");
  a_line6: assert property (p_line6)
    else $error("line 6 source wrong");
  a_line7: assert property (p_line7)
    else $error("line 7 source wrong");
  a_line10: assert property (p_line10)
    else $error("line 10 source wrong");
  a_line11: assert property (p_line11)
    else $error("line 11 source wrong");
  a_go_en: assert property (p_go_en)
    else $error("go on disabled channel");
  a_mask_quiet: assert property (p_mask_quiet)
    else $error("dma_irq with mask clear");
endmodule // dmaic_ctrl_props

bind dmaic_ctrl dmaic_ctrl_props i_props
(
  .clk, .reset, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .chan_go, .port2_rx_irq, .port2_tx_irq, .port1_rx_irq, .port1_tx_irq,
  .cpu_irq_6, .cpu_irq_7, .cpu_irq_10, .cpu_irq_11, .dma_irq
);

// ---- test/dmaic_far_model.sv ----
// far side model: transfer engine and sync event sources
// assumes the bench calls fire() and drives slow
`timescale 1ns/1ps

module dmaic_far_model
  import dmaic_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // engine
  input  wire logic       slow,
  input  wire logic [5:0] chan_go,
  output logic      [5:0] elem_done,
  // sync events
  output logic      [2:0] rx_evt,
  output logic      [2:0] tx_evt,
  output logic      [2:0] rx_va,
  output logic      [2:0] tx_va,
  output logic            timer_evt,
  output logic            ext3_evt
);
  logic [1:0] rest [6];

  initial
  begin
    {rx_evt, tx_evt, rx_va, tx_va, timer_evt, ext3_evt} = 14'h0000;
  end

  // rest lets the counter update reach chan_go before the next look
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < 6; c++)
    begin
      if (reset)
      begin
        elem_done[c] <= 1'b0;
        rest[c]      <= 2'h0;
      end
      else if (elem_done[c])
      begin
        elem_done[c] <= 1'b0;
        rest[c]      <= slow ? 2'h3 : 2'h1;
      end
      else if (rest[c] != 2'h0)
        rest[c] <= rest[c] - 2'h1;
      else
        elem_done[c] <= chan_go[c];
    end
  end

  task automatic fire(input logic [3:0] code);
    logic [3:0] k;
    logic [2:0] port;
    logic       lo;
    logic       hi;
    lo   = code >= 4'h1 && code <= 4'h6;
    hi   = code >= 4'h7 && code <= 4'hC;
    k    = hi ? code - 4'h7 : code - 4'h1;
    port = k[2:1] == 2'h0 ? 3'h1 : k[2:1] == 2'h1 ? 3'h4 : 3'h2;
    @(posedge clk);
    rx_evt    <= lo && !k[0] ? port : 3'h0;
    tx_evt    <= lo && k[0] ? port : 3'h0;
    rx_va     <= hi && !k[0] ? port : 3'h0;
    tx_va     <= hi && k[0] ? port : 3'h0;
    timer_evt <= code == 4'hD;
    ext3_evt  <= code == 4'hE;
    @(posedge clk);
    {rx_evt, tx_evt, rx_va, tx_va, timer_evt, ext3_evt} <= 14'h0000;
  endtask
endmodule // dmaic_far_model

// ---- test/tb.sv ----
// self-checking bench of dmaic_ctrl beside the far side model
// assumes a single clock; ce drops only for the freeze check
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module tb
  import dmaic_pkg::*;
;
  logic        clk       = 1'b0;
  logic        reset     = 1'b1;
  logic        ce        = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  dmaic_word_t reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        slow      = 1'b0;
  logic [3:0]  pirq      = 4'h0;
  dmaic_word_t reg_rdata;
  logic [2:0]  rx_evt, tx_evt, rx_va, tx_va;
  logic        timer_evt, ext3_evt, irq4, irq5, dma_irq, autobuf, irq_mode, ien;
  logic [5:0]  chan_go, elem_done, xs;
  logic [1:0]  route, sl;
  wire  [3:0]  lines;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          per, bst;
  dmaic_word_t rv, e0, e1, f0, f1, sa, da;

  always #2.5 clk = ~clk;

  dmaic_ctrl i_dut
  (
    .clk, .reset, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_rx_evt(rx_evt), .port_tx_evt(tx_evt), .port_rx_evt_va(rx_va),
    .port_tx_evt_va(tx_va), .timer_evt, .ext3_evt, .chan_go, .elem_done,
    .port2_rx_irq(pirq[0]), .port2_tx_irq(pirq[1]), .port1_rx_irq(pirq[2]),
    .port1_tx_irq(pirq[3]), .cpu_irq_6(lines[0]), .cpu_irq_7(lines[1]),
    .cpu_irq_10(lines[2]), .cpu_irq_11(lines[3]), .chan4_irq(irq4),
    .chan5_irq(irq5), .dma_irq
  );

  dmaic_far_model i_far
  (
    .clk, .reset, .slow, .chan_go, .elem_done, .rx_evt, .tx_evt, .rx_va,
    .tx_va, .timer_evt, .ext3_evt
  );

  task automatic wr(input logic [7:0] a, input dmaic_word_t d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask

  task automatic pace();
    i_far.fire(4'hD);
    repeat (8) @(posedge clk);
  endtask

  function automatic logic [7:0] ca(int c, int f);
    return 8'(16 + 8 * c + f);
  endfunction

  // wraps at 16 bits, so negative indices walk backwards
  function automatic dmaic_word_t adv(dmaic_word_t a, logic sel, int n, int p);
    for (int k = 0; k < n; k++)
      a = a + ((k % p == p - 1) ? (sel ? f1 : f0) : (sel ? e1 : e0));
    return a;
  endfunction

  // bit order: lines 11, 10, 7, 6
  function automatic logic [3:0] exp_lines(logic [1:0] r, logic [3:0] p, logic [3:0] ch);
    if (r == 2'h2)
      return ch;
    if (r == 2'h1)
      return {ch[3:2], p[1:0]};
    return p;
  endfunction

  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // whole run needs about 1100 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  initial
  begin
    void'($urandom(22898));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int i = 4; i < 7; i++)
    begin
      rd(8'(i));
      `CHK(rv, 16'h0000)
    end
    wr(8'h07, 16'hFFFF);
    rd(8'h07);
    `CHK(rv, 16'h0000)
    rd(8'h40);
    `CHK(rv, 16'h0000)
    // a frozen block takes no write
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h06, 16'h003F);
    ce <= 1'b1;
    rd(8'h06);
    `CHK(rv, 16'h0000)
    // every sync code, each first offered a foreign event
    for (int s = 0; s < 16; s++)
    begin
      wr(ca(2, 0), 16'h8000);
      wr(ca(2, 1), {4'(s), 12'h000});
      wr(ca(2, 2), 16'h0000);
      wr(8'h04, 16'h0004);
      i_far.fire(4'((s % 14) + 1));
      repeat (4) @(posedge clk);
      rd(8'h05);
      `CHK(rv, (s == 0) ? 16'h0004 : 16'h0000)
      if (s != 0 && s != 15)
        i_far.fire(4'(s));
      repeat (8) @(posedge clk);
      rd(8'h05);
      `CHK(rv, (s == 15) ? 16'h0000 : 16'h0004)
      wr(8'h04, 16'h0000);
      wr(8'h05, 16'h003F);
    end
    // multiframe and autobuffer, both interrupt modes and disabled
    for (int m = 0; m < 5; m++)
    begin
      autobuf  = m > 2;
      irq_mode = m == 1 || m == 4;
      ien      = m != 2;
      per      = autobuf ? 4 : 3;
      bst      = autobuf ? 2 : 3;
      sl       = 2'($urandom);
      e0   = 16'($urandom);
      e1   = 16'($urandom);
      f0   = 16'($urandom);
      f1   = 16'($urandom);
      sa   = 16'($urandom);
      da   = 16'($urandom);
      slow <= 1'($urandom);
      wr(8'h00, e0);
      wr(8'h01, e1);
      wr(8'h02, f0);
      wr(8'h03, f1);
      wr(ca(m, 0), {ien, irq_mode, autobuf, 9'h000, 2'h3, sl});
      wr(ca(m, 1), 16'hD001);
      wr(ca(m, 2), 16'(per - 1));
      wr(ca(m, 3), 16'(per - 1));
      wr(ca(m, 4), sa);
      wr(ca(m, 5), da);
      wr(8'h04, 16'(1 << m));
      for (int h = 1; h < 3; h++)
      begin
        repeat (bst) pace();
        xs = (h == 2 ? ien : ien && irq_mode) ? 6'(1 << m) : 6'h00;
        rd(8'h05);
        `CHK(rv[5:0], xs)
        wr(8'h05, 16'h003F);
        rd(ca(m, 4));
        `CHK(rv, adv(sa, sl[1], h * bst, per))
        rd(ca(m, 5));
        `CHK(rv, adv(da, sl[0], h * bst, per))
        rd(ca(m, 2));
        `CHK(rv, 16'((per * 4 - 1 - h * bst) % per))
        if (!autobuf && h == 1)
        begin
          rd(ca(m, 1));
          `CHK(rv, 16'hD000)
        end
      end
      rd(8'h04);
      `CHK(rv[m], autobuf)
      wr(8'h04, 16'h0000);
    end
    // all six channels pending, then every route setting
    wr(8'h06, 16'h003F);
    for (int c = 0; c < 6; c++)
    begin
      wr(ca(c, 0), 16'h8000);
      wr(ca(c, 1), 16'h0000);
      wr(ca(c, 2), 16'h0000);
    end
    wr(8'h04, 16'h003F);
    repeat (8) @(posedge clk);
    `CHK({irq5, irq4, dma_irq}, 3'h7)
    for (int r = 0; r < 4; r++)
    begin
      route = 2'(r);
      wr(8'h04, {4'h0, route, 10'h000});
      pirq <= 4'($urandom);
      repeat (3) @(posedge clk);
      `CHK({lines, irq5, irq4}, {exp_lines(route, pirq, 4'hF), 2'h3})
    end
    wr(8'h04, 16'h0800);
    wr(8'h05, 16'h003F);
    repeat (3) @(posedge clk);
    `CHK({lines, irq5, irq4, dma_irq}, 7'h00)
    end_sim();
  end
endmodule // tb
